// ### fsp_security_top.sv
`timescale 1ns/1ns
// Behaviour
// (RULE_01) Options register loaded from nonvolatile byte at reset.
// (RULE_02) Software reprograms option byte, then resets.
// (RULE_03) Key enable zero forbids backdoor unsecure.
// (RULE_04) Key writes only from secured firmware.
// (RULE_05) Matching eight-byte key unsecures until reset.
// (RULE_06) Redirect disable bit turns redirection off.
// (RULE_07) Only security code 1:0 is unsecured.
// (RULE_08) Secured blocks unsecured memory access.
// (RULE_09) Key match or blank check unsecures.
// (RULE_10) Key access zero: key writes start commands.
// (RULE_11) Key access one: key writes captured.
// (RULE_12) Protection register loaded from nonvolatile byte.
// (RULE_13) Protection readable; user writes ignored.
// (RULE_14) Debug writes update protection register.
// (RULE_15) Select field sets protected boundary.
// (RULE_16) Program or erase in region rejected.
// (RULE_17) Disable bit one leaves nothing protected.
// (RULE_18) Boundary in 512-byte steps; above protected.
// (RULE_19) Software clears key access to compare.
// (RULE_20) Control registers are eight bits wide.
module fsp_security_top
  import fsp_pkg::*;
(
  // Clock and reset.
  input  wire logic                       CLK_SYS,
  input  wire logic                       NRST,
  // Nonvolatile contents.
  input  wire logic [7:0]                 NV_OPTION_BYTE,
  input  wire logic [7:0]                 NV_PROTECT_BYTE,
  input  wire logic [FSP_KEY_BYTES*8-1:0] NV_BACKDOOR_KEY,
  // Register port.
  input  wire logic [3:0]                 REG_ADDR,
  input  wire logic [7:0]                 REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  input  wire logic                       REG_DEBUG,
  output logic [7:0]                      REG_RDATA,
  // Memory write path.
  input  wire fsp_cpu_wr_s                MEM_WR,
  input  wire logic                       MEM_ACCESS_REQ,
  input  wire logic                       MEM_ACCESS_UNSECURE_SRC,
  input  wire logic                       BLANK_CHECK_PASS,
  input  wire logic                       OP_REQ,
  input  wire logic [15:0]                OP_ADDR,
  output logic                            CMD_START,
  output logic [15:0]                     CMD_ADDR,
  output logic [7:0]                      CMD_DATA,
  output logic                            OP_REJECT,
  output logic                            MEM_ACCESS_BLOCK,
  // Status.
  output logic                            SECURED,
  output logic                            VECTOR_REDIRECT_EN
);

  // ---------------------------------------------------------------------------
  // Loaded state.
  // ---------------------------------------------------------------------------
  logic [7:0] options_reg;
  logic [7:0] protect_reg;
  logic [7:0] config_reg;
  logic       loaded_reg;
  logic       unsec_reg;
  logic       key_written_reg;
  logic       key_match;
  logic       key_hit;
  logic       prot_hit;
  logic       reg_wr_cfg;
  logic [1:0] sec_code;
  logic [7:0] rdata_next;

  // Option and protection bytes are caught on the first edge after release.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      loaded_reg  <= 1'b0;
      options_reg <= FSP_BYTE_ZERO;
      protect_reg <= FSP_BYTE_ZERO;
    end else if (!loaded_reg) begin
      loaded_reg  <= 1'b1;
      options_reg <= NV_OPTION_BYTE; // [RULE_01]
      protect_reg <= NV_PROTECT_BYTE; // [RULE_12]
    end else if (REG_WR && REG_DEBUG && REG_ADDR == FSP_OFF_PROTECT) begin
      protect_reg <= REG_WDATA; // [RULE_13] [RULE_14]
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration and key entry.
  // ---------------------------------------------------------------------------
  assign reg_wr_cfg = REG_WR && REG_ADDR == FSP_OFF_CONFIG;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      config_reg <= FSP_CFG_RESET;
    end else if (reg_wr_cfg) begin
      config_reg <= REG_WDATA;
    end
  end

  assign key_hit = MEM_WR.wr && MEM_WR.addr >= FSP_KEY_BASE && MEM_WR.addr <= FSP_KEY_LAST;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      key_written_reg <= 1'b0;
    end else if (key_hit && config_reg[FSP_CFG_KEY_ACCESS_ENABLE_BIT] && MEM_WR.secure_src && !MEM_WR.debug) begin
      key_written_reg <= 1'b1; // [RULE_04] [RULE_11]
    end else if (reg_wr_cfg && !REG_WDATA[FSP_CFG_KEY_ACCESS_ENABLE_BIT]) begin
      key_written_reg <= 1'b0;
    end
  end

  fsp_key_cmp u_key (
    .clk        (CLK_SYS),
    .nrst       (NRST),
    .clear      (1'b0),
    .load       (key_hit && config_reg[FSP_CFG_KEY_ACCESS_ENABLE_BIT] && MEM_WR.secure_src && !MEM_WR.debug), // [RULE_04]
    .idx        (MEM_WR.addr[2:0]),
    .data       (MEM_WR.data),
    .stored_key (NV_BACKDOOR_KEY),
    .match      (key_match)
  );

  // Unsecure latch: held until reset; key path gated by key enable.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      unsec_reg <= 1'b0;
    end else if (BLANK_CHECK_PASS) begin
      unsec_reg <= 1'b1; // [RULE_09]
    end else if (reg_wr_cfg && config_reg[FSP_CFG_KEY_ACCESS_ENABLE_BIT] && !REG_WDATA[FSP_CFG_KEY_ACCESS_ENABLE_BIT]
                 && key_written_reg && key_match && options_reg[FSP_OPT_BACKDOOR_KEY_ENABLE_BIT]) begin
      unsec_reg <= 1'b1; // [RULE_03] [RULE_05] [RULE_19]
    end
  end

  assign sec_code = unsec_reg ? FSP_SEC_UNSECURED : options_reg[1:0]; // [RULE_09]

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign SECURED            = loaded_reg ? (sec_code != FSP_SEC_UNSECURED) : 1'b1; // [RULE_07]
  assign VECTOR_REDIRECT_EN = loaded_reg && !options_reg[FSP_OPT_NORED_BIT]; // [RULE_06]
  assign MEM_ACCESS_BLOCK   = SECURED && MEM_ACCESS_REQ && MEM_ACCESS_UNSECURE_SRC; // [RULE_08]

  fsp_region_chk u_region (
    .prot          (protect_reg),
    .addr          (OP_ADDR),
    .protected_hit (prot_hit)
  );

  assign OP_REJECT = OP_REQ && (prot_hit || !loaded_reg); // [RULE_16]

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CMD_START <= 1'b0;
      CMD_ADDR  <= 16'h0000;
      CMD_DATA  <= FSP_BYTE_ZERO;
    end else begin
      CMD_START <= MEM_WR.wr && (!key_hit || !config_reg[FSP_CFG_KEY_ACCESS_ENABLE_BIT]); // [RULE_10]
      CMD_ADDR  <= MEM_WR.addr;
      CMD_DATA  <= MEM_WR.data;
    end
  end

  always_comb begin
    rdata_next = FSP_BYTE_ZERO;
    case (REG_ADDR)
      FSP_OFF_OPTIONS: rdata_next = {options_reg[7:2], sec_code}; // [RULE_20]
      FSP_OFF_CONFIG:  rdata_next = config_reg & (8'h01 << FSP_CFG_KEY_ACCESS_ENABLE_BIT);
      FSP_OFF_PROTECT: rdata_next = protect_reg; // [RULE_13]
      FSP_OFF_STATUS:  rdata_next = {6'h00, key_match, SECURED};
      default:         rdata_next = FSP_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= FSP_BYTE_ZERO;
    end else begin
      REG_RDATA <= REG_RD ? rdata_next : FSP_BYTE_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_options_load: assert property ($rose(loaded_reg) |-> options_reg == $past(NV_OPTION_BYTE)) // [RULE_01]
    else $error("options not loaded");
  a_protect_load: assert property ($rose(loaded_reg) |-> protect_reg == $past(NV_PROTECT_BYTE)) // [RULE_12]
    else $error("protection not loaded");
  a_backdoor_key_enable_gate: assert property (loaded_reg && !options_reg[7] && !BLANK_CHECK_PASS && !unsec_reg
                                 |=> !unsec_reg) // [RULE_03]
    else $error("unsecured with key disabled");
  a_debug_key: assert property (MEM_WR.wr && (MEM_WR.debug || !MEM_WR.secure_src) && !key_written_reg
                                |=> !key_written_reg) // [RULE_04]
    else $error("debug loaded key");
  a_sec_decode: assert property (loaded_reg && !unsec_reg |-> SECURED == (options_reg[1:0] != 2'h2)) // [RULE_07]
    else $error("bad security decode");
  a_mem_block: assert property (SECURED && MEM_ACCESS_REQ && MEM_ACCESS_UNSECURE_SRC |-> MEM_ACCESS_BLOCK) // [RULE_08]
    else $error("access not blocked");
  a_blank_unsec: assert property (BLANK_CHECK_PASS && loaded_reg |=> !SECURED [*3]) // [RULE_09]
    else $error("blank check did not unsecure");
  a_cmd_start: assert property (MEM_WR.wr && !config_reg[5] |=> CMD_START) // [RULE_10]
    else $error("command not started");
  a_key_capture: assert property (key_hit && config_reg[5] |=> !CMD_START) // [RULE_11]
    else $error("key write started command");
  a_user_prot: assert property (loaded_reg && !(REG_WR && REG_DEBUG) |=> $stable(protect_reg)) // [RULE_13]
    else $error("protection changed by user");
  a_region_rej: assert property (OP_REQ && !protect_reg[0] && OP_ADDR > {protect_reg[7:1], 9'h1FF}
                                 |-> OP_REJECT) // [RULE_16]
    else $error("protected op not rejected");
  a_no_prot: assert property (loaded_reg && OP_REQ && protect_reg[0] |-> !OP_REJECT) // [RULE_17]
    else $error("rejected with protection off");

endmodule : fsp_security_top

// ### fsp_pkg.sv
package fsp_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (software register port).
  // ---------------------------------------------------------------------------
  localparam logic [3:0] FSP_OFF_OPTIONS  = 4'h0;
  localparam logic [3:0] FSP_OFF_CONFIG   = 4'h1;
  localparam logic [3:0] FSP_OFF_PROTECT  = 4'h2;
  localparam logic [3:0] FSP_OFF_STATUS   = 4'h3;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int FSP_OPT_BACKDOOR_KEY_ENABLE_BIT   = 7;
  localparam int FSP_OPT_NORED_BIT   = 6;
  localparam int FSP_CFG_KEY_ACCESS_ENABLE_BIT  = 5;
  localparam int FSP_PROT_DIS_BIT    = 0;
  localparam int FSP_STAT_SEC_BIT    = 0;
  localparam int FSP_STAT_MATCH_BIT  = 1;

  // ---------------------------------------------------------------------------
  // Codes, reset values and address map.
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  FSP_SEC_UNSECURED = 2'h2;
  localparam logic [7:0]  FSP_CFG_RESET     = 8'h00;
  localparam logic [15:0] FSP_KEY_BASE      = 16'hFFB0;
  localparam logic [15:0] FSP_KEY_LAST      = 16'hFFB7;
  localparam int          FSP_KEY_BYTES     = 8;
  localparam int          FSP_BLOCK_SHIFT   = 9;
  localparam logic [7:0]  FSP_BYTE_ZERO     = 8'h00;

  typedef struct packed {
    logic       wr;
    logic [15:0] addr;
    logic [7:0] data;
    logic       debug;
    logic       secure_src;
  } fsp_cpu_wr_s;

endpackage : fsp_pkg

// ### fsp_key_cmp.sv
`timescale 1ns/1ns
module fsp_key_cmp
  import fsp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      clear,
  input  wire logic                      load,
  input  wire logic [2:0]                idx,
  input  wire logic [7:0]                data,
  input  wire logic [FSP_KEY_BYTES*8-1:0] stored_key,
  output logic                           match
);

  logic [7:0] key_reg [FSP_KEY_BYTES];
  logic [FSP_KEY_BYTES-1:0] hit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FSP_KEY_BYTES; i++) key_reg[i] <= FSP_BYTE_ZERO;
    end else if (clear) begin
      for (int i = 0; i < FSP_KEY_BYTES; i++) key_reg[i] <= FSP_BYTE_ZERO;
    end else if (load) begin
      key_reg[idx] <= data;
    end
  end

  // Byte i of the key sits at address base+i; all eight bytes are compared at once.
  always_comb begin
    for (int i = 0; i < FSP_KEY_BYTES; i++) hit[i] = (key_reg[i] == stored_key[i*8 +: 8]);
  end

  assign match = &hit;

endmodule : fsp_key_cmp

// ### fsp_region_chk.sv
`timescale 1ns/1ns
module fsp_region_chk
  import fsp_pkg::*;
(
  input  wire logic [7:0]  prot,
  input  wire logic [15:0] addr,
  output logic             protected_hit
);

  logic [15:0] boundary;

  // The select field gives the last unprotected 512-byte block.
  assign boundary      = {prot[7:1], {FSP_BLOCK_SHIFT{1'b1}}};
  assign protected_hit = !prot[FSP_PROT_DIS_BIT] && (addr > boundary); // [RULE_15] [RULE_17] [RULE_18]

endmodule : fsp_region_chk

// ### test_fsp_security_top.sv
`timescale 1ns/1ns
module test_fsp_security_top;
  import fsp_pkg::*;
  logic                       CLK_SYS;
  logic                       NRST = 1'b0;
  logic [7:0]                 NV_OPTION_BYTE = 8'h00;
  logic [7:0]                 NV_PROTECT_BYTE = 8'h00;
  logic [FSP_KEY_BYTES*8-1:0] NV_BACKDOOR_KEY = '0;
  logic [3:0]                 REG_ADDR = 4'h0;
  logic [7:0]                 REG_WDATA = 8'h00;
  logic                       REG_WR = 1'b0;
  logic                       REG_RD = 1'b0;
  logic                       REG_DEBUG = 1'b0;
  fsp_cpu_wr_s                MEM_WR = '0;
  logic                       MEM_ACCESS_REQ = 1'b0;
  logic                       MEM_ACCESS_UNSECURE_SRC = 1'b0;
  logic                       BLANK_CHECK_PASS = 1'b0;
  logic                       OP_REQ = 1'b0;
  logic [15:0]                OP_ADDR = 16'h0000;
  logic [7:0]                 REG_RDATA, CMD_DATA, opt, prot;
  logic [15:0]                CMD_ADDR;
  logic                       CMD_START, OP_REJECT, MEM_ACCESS_BLOCK, SECURED, VECTOR_REDIRECT_EN, unlocked;
  int                         err_total = 0;
  int                         comparisons = 0;

  fsp_security_top fsp_security_top_inst (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .NV_OPTION_BYTE(NV_OPTION_BYTE), .NV_PROTECT_BYTE(NV_PROTECT_BYTE),
    .NV_BACKDOOR_KEY(NV_BACKDOOR_KEY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_DEBUG(REG_DEBUG), .REG_RDATA(REG_RDATA), .MEM_WR(MEM_WR),
    .MEM_ACCESS_REQ(MEM_ACCESS_REQ), .MEM_ACCESS_UNSECURE_SRC(MEM_ACCESS_UNSECURE_SRC),
    .BLANK_CHECK_PASS(BLANK_CHECK_PASS), .OP_REQ(OP_REQ), .OP_ADDR(OP_ADDR), .CMD_START(CMD_START),
    .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .OP_REJECT(OP_REJECT), .MEM_ACCESS_BLOCK(MEM_ACCESS_BLOCK),
    .SECURED(SECURED), .VECTOR_REDIRECT_EN(VECTOR_REDIRECT_EN));

  // ---------------------------------------------------------------------------
  // Bus tasks and expectations.
  // ---------------------------------------------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  function automatic logic rej(input logic [7:0] p, input logic [15:0] a);
    return !p[FSP_PROT_DIS_BIT] && (a > {p[7:1], 9'h1FF});
  endfunction : rej

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
    @(posedge CLK_SYS);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_DEBUG <= dbg;
    REG_WR    <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(negedge CLK_SYS);
    chk(REG_RDATA, e);
  endtask : reg_rd

  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d, input logic dbg, input logic cmd);
    @(posedge CLK_SYS);
    MEM_WR <= '{wr: 1'b1, addr: a, data: d, debug: dbg, secure_src: 1'b1};
    @(posedge CLK_SYS);
    MEM_WR.wr <= 1'b0;
    @(negedge CLK_SYS);
    chk(CMD_START, cmd);
    if (cmd) chk({CMD_DATA, CMD_ADDR[7:0]}, {d, a[7:0]});
  endtask : mem_wr

  task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
    @(posedge CLK_SYS);
    NRST            <= 1'b0;
    NV_OPTION_BYTE  <= o;
    NV_PROTECT_BYTE <= p;
    NV_BACKDOOR_KEY <= {$urandom, $urandom};
    repeat (5) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    opt      = o;
    prot     = p;
    unlocked = 1'b0;
  endtask : do_reset

  task automatic chk_state;
    logic s;
    @(posedge CLK_SYS);
    MEM_ACCESS_REQ          <= 1'($urandom);
    MEM_ACCESS_UNSECURE_SRC <= 1'b1;
    @(negedge CLK_SYS);
    s = (opt[1:0] != FSP_SEC_UNSECURED) && !unlocked;
    chk(SECURED, s);
    chk(VECTOR_REDIRECT_EN, !opt[FSP_OPT_NORED_BIT]);
    chk(MEM_ACCESS_BLOCK, s & MEM_ACCESS_REQ);
  endtask : chk_state

  task automatic key_seq(input logic [63:0] k, input logic dbg);
    reg_wr(FSP_OFF_CONFIG, 8'(1 << FSP_CFG_KEY_ACCESS_ENABLE_BIT), 1'b0);
    for (int i = 0; i < FSP_KEY_BYTES; i++) mem_wr(FSP_KEY_BASE + 16'(i), k[8*i +: 8], dbg, 1'b0);
    reg_wr(FSP_OFF_CONFIG, 8'h00, 1'b0);
    @(posedge CLK_SYS);
    chk_state;
  endtask : key_seq

  task automatic report_and_stop;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] p;
    void'($urandom(32'h208E));
    for (int i = 0; i < 4; i++) begin
      do_reset({6'($urandom), 2'(i)}, 8'($urandom));
      reg_rd(FSP_OFF_OPTIONS, opt);
      reg_rd(FSP_OFF_PROTECT, prot);
      chk_state;
      @(posedge CLK_SYS);
      NV_OPTION_BYTE <= ~opt;
      reg_wr(FSP_OFF_OPTIONS, ~opt, 1'b0);
      reg_rd(FSP_OFF_OPTIONS, opt);
      reg_rd(4'hF, 8'h00);
      $display("options code %0d done", i);
    end
    reg_wr(FSP_OFF_PROTECT, ~prot, 1'b0);
    reg_rd(FSP_OFF_PROTECT, prot);
    for (int j = 0; j < 6; j++) begin
      p = (j == 0) ? 8'h00 : (j == 1) ? 8'hFE : 8'($urandom);
      if (j < 4) p[FSP_PROT_DIS_BIT] = 1'b0;
      reg_wr(FSP_OFF_PROTECT, p, 1'b1);
      prot = p;
      reg_rd(FSP_OFF_PROTECT, prot);
      for (int n = 0; n < 8; n++) begin
        @(posedge CLK_SYS);
        OP_REQ  <= 1'b1;
        OP_ADDR <= (n < 2) ? {p[7:1], 9'h1FF} + 16'(n) : 16'($urandom);
        @(negedge CLK_SYS);
        chk(OP_REJECT, rej(prot, OP_ADDR));
      end
    end
    $display("protection done");
    do_reset(8'h80, 8'h01);
    mem_wr(FSP_KEY_BASE + 16'h0003, 8'($urandom), 1'b0, 1'b1);
    key_seq(NV_BACKDOOR_KEY, 1'b1);
    key_seq(~NV_BACKDOOR_KEY, 1'b0);
    unlocked = 1'b1;
    key_seq(NV_BACKDOOR_KEY, 1'b0);
    do_reset(8'h80, 8'h01);
    chk_state;
    do_reset(8'h00, 8'h01);
    key_seq(NV_BACKDOOR_KEY, 1'b0);
    @(posedge CLK_SYS);
    BLANK_CHECK_PASS <= 1'b1;
    @(posedge CLK_SYS);
    BLANK_CHECK_PASS <= 1'b0;
    unlocked = 1'b1;
    @(posedge CLK_SYS);
    chk_state;
    $display("key and blank check done");
    report_and_stop;
  end

  // The tests need under 300 cycles; this 20,000-cycle span leaves ample margin.
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
endmodule : test_fsp_security_top
